/* File: shared/sync_serial_port_pkg.sv */
package sync_serial_port_pkg;

	// ------------------------------------------------------------
	// Data path sizes
	// ------------------------------------------------------------
	localparam int BYTE_BITS = 8; // Shift register length
	localparam int HALF_BITS = 12; // Width of the half-period counter
	localparam int EDGE_LAST = 15; // Last of sixteen clock edges per byte

	// ------------------------------------------------------------
	// Host clock rates, as system clocks per serial half period
	// ------------------------------------------------------------
	localparam logic [11:0] HALF_DIV4 = 12'h0002; // Fosc/4
	localparam logic [11:0] HALF_DIV16 = 12'h0008; // Fosc/16
	localparam logic [11:0] HALF_DIV64 = 12'h0020; // Fosc/64

	// Five host clocking modes
	typedef enum logic [2:0] {
		RATE_DIV4,
		RATE_DIV16,
		RATE_DIV64,
		RATE_TIMER,
		RATE_RELOAD
	} rate_sel_t;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] BUF_RESET = 8'h00; // Data buffer after reset
	localparam logic [7:0] STATUS_RESET = 8'h00; // Status image after reset
	localparam logic [7:0] CTRL_RESET = 8'h00; // Control image after reset

	// ------------------------------------------------------------
	// Status image layout
	// ------------------------------------------------------------
	localparam int STAT_SMP_POS = 7; // Sample phase, software owned
	localparam int STAT_CKE_POS = 6; // Clock edge, software owned
	localparam int STAT_BF_POS = 0; // Buffer full, read-only

	// ------------------------------------------------------------
	// Control image layout
	// ------------------------------------------------------------
	localparam int CTRL_WRITE_COLLISION_FLAG_POS = 7; // Write collision
	localparam int CTRL_EN_POS = 5; // Port enable
	localparam int CTRL_CKP_POS = 4; // Clock idle level
	localparam int CTRL_HOST_POS = 3; // Host when set

endpackage

/* File: verilog/sync_serial_port_spi_core.sv */
// What this block does
// - Port runs SPI only; other protocol idles it
// - Host drives clock, client receives it
// - Each clock period moves one bit each way
// - Only host starts; client waits for clocks
// - Four lines: clock, out, in, select
// - Client obeys select; framing may follow it
// - Unselected client floats its data output
// - First control image reads back settings; bit 6 reads zero
// - Status: six low read-only, two high config
// - Only reload mode uses rate reload value
// - Shift register reached only through buffer
// - Completed byte to buffer, raise flag
// - Buffer write loads buffer and shifter together
// - Eight bits, MSB out, new bit at LSB
// - Write during transfer dropped, collision flagged
// - Full flag set on load, cleared on read
// - Unselected client ignores clock and data
`timescale 1ns/1ps
`default_nettype none

module sync_serial_port_spi_core (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic protocolSpi,
	input wire logic portEnable,
	input wire logic hostMode,
	input wire logic clkPolarity,
	input wire logic clkEdge,
	input wire logic sampleEnd,
	input wire sync_serial_port_pkg::rate_sel_t rateSel,
	input wire logic [7:0] spi_rate_reload,
	input wire logic timerTick,
	input wire logic selectSyncEn,
	input wire logic bufWrite,
	input wire logic [7:0] bufWriteData,
	input wire logic bufRead,
	input wire logic collisionClear,
	input wire logic irqClear,
	output logic [7:0] spi_data_buffer,
	output logic [7:0] spi_status_reg,
	output logic [7:0] spi_control_one,
	output logic write_collision_flag,
	output logic rx_buffer_full_flag,
	output logic spi_irq_flag,
	output logic sckOut,
	output logic sckOe_b,
	input wire logic sckIn,
	output logic sdoOut,
	output logic sdoOe_b,
	input wire logic sdiIn,
	input wire logic ssIn_b
);
	import sync_serial_port_pkg::*;

	// ------------------------------------------------------------
	// Configuration
	// ------------------------------------------------------------
	logic active; // Port on and in SPI protocol
	assign active = portEnable & protocolSpi;

	// Host state machine
	typedef enum logic {HOST_IDLE, HOST_SHIFT} host_state_t;
	host_state_t hostState_r; // Host sequencer state

	// ------------------------------------------------------------
	// Pin synchronisers into the system clock
	// ------------------------------------------------------------
	logic sdiMeta_r; // First stage, read only by the second
	logic sdiSync_r; // Data in, safe to use
	logic ssMeta_r; // First stage of select
	logic ssSync_b_r; // Select, safe to use
	logic [2:0] doneSync_r; // Client byte-done toggle crossing

	// Two flops before system-clock logic looks at data in or select; client flops use the raw pins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sdiMeta_r <= 1'b0;
			sdiSync_r <= 1'b0;
			ssMeta_r <= 1'b1;
			ssSync_b_r <= 1'b1;
		end else begin
			sdiMeta_r <= sdiIn;
			sdiSync_r <= sdiMeta_r;
			ssMeta_r <= ssIn_b;
			ssSync_b_r <= ssMeta_r;
		end
	end

	// ------------------------------------------------------------
	// Client side, on the link clock
	// ------------------------------------------------------------
	logic sckNorm; // Serial clock with idle level folded to zero
	logic sampleClk; // Rising edge is the client sampling edge
	logic clientRst_b; // Reset, or select released with sync on
	logic [2:0] clientCnt_r; // Bits taken in the current byte
	logic [7:0] clientSh_r; // Client receive shifter
	logic [7:0] clientRx_r; // Last byte the client completed
	logic clientDoneTgl_r; // Toggles once per completed byte
	logic clientSdo_r; // Client data bit after first edge
	logic [7:0] txByte_r; // Byte loaded for transmit, both modes
	logic clientTake; // Link edges count: selected client, port on

	assign sckNorm = sckIn ^ clkPolarity;
	assign sampleClk = sckNorm ^ ~clkEdge;
	assign clientTake = !ssIn_b && !hostMode && active;
	// With sync on, releasing select clears framing; clock-tree gating traded for
	// immediate resync without needing any clock edge
	assign clientRst_b = rst_b & ~(selectSyncEn & ssIn_b);

	// Sampling edge: shift new bit into LSB, count the byte
	always_ff @(posedge sampleClk or negedge clientRst_b) begin
		if (!clientRst_b) begin
			clientCnt_r <= 3'd0;
			clientSh_r <= BUF_RESET;
		end else if (clientTake) begin
			clientSh_r <= {clientSh_r[6:0], sdiIn};
			clientCnt_r <= clientCnt_r + 3'd1;
		end
	end

	// Hand-over flops see only the full reset: a select release must
	// not flip the toggle, or the system side would take a false byte
	always_ff @(posedge sampleClk or negedge rst_b) begin
		if (!rst_b) begin
			clientRx_r <= BUF_RESET;
			clientDoneTgl_r <= 1'b0;
		end else if (clientTake && clientCnt_r == 3'(BYTE_BITS - 1)) begin
			clientRx_r <= {clientSh_r[6:0], sdiIn};
			clientDoneTgl_r <= ~clientDoneTgl_r;
		end
	end

	// Opposite edge: present the next bit, MSB first
	always_ff @(negedge sampleClk or negedge clientRst_b) begin
		if (!clientRst_b) begin
			clientSdo_r <= 1'b0;
		end else if (!ssIn_b) begin
			clientSdo_r <= txByte_r[3'(BYTE_BITS - 1) - clientCnt_r];
		end
	end

	// Byte-done toggle into the system clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			doneSync_r <= 3'b000;
		end else begin
			doneSync_r <= {doneSync_r[1:0], clientDoneTgl_r};
		end
	end

	logic clientDone; // One-cycle pulse per client byte
	assign clientDone = doneSync_r[2] ^ doneSync_r[1];

	// ------------------------------------------------------------
	// Host rate generator
	// ------------------------------------------------------------
	logic [11:0] halfLimit; // System clocks per half period
	logic [11:0] halfCnt_r; // Counts up to one below the limit
	logic halfTick; // One half period elapsed

	// Only the reload mode looks at the reload value
	always_comb begin
		case (rateSel)
			RATE_DIV16: halfLimit = HALF_DIV16;
			RATE_DIV64: halfLimit = HALF_DIV64;
			RATE_RELOAD: halfLimit = {3'b000, spi_rate_reload, 1'b0} + 12'h0002;
			default: halfLimit = HALF_DIV4;
		endcase
	end

	assign halfTick = (rateSel == RATE_TIMER) ? timerTick :
		(halfCnt_r == halfLimit - 12'h0001);

	// Counter runs only while a byte is shifting
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			halfCnt_r <= 12'h0000;
		end else if (hostState_r != HOST_SHIFT || halfTick) begin
			halfCnt_r <= 12'h0000;
		end else begin
			halfCnt_r <= halfCnt_r + 12'h0001;
		end
	end

	// ------------------------------------------------------------
	// Host sequencer
	// ------------------------------------------------------------
	logic [3:0] edgeCnt_r; // Sixteen edges per byte
	logic [7:0] hostSh_r; // Host shifter
	logic hostSdo_r; // Host data bit
	logic sckLevel_r; // Normalised host clock, zero at rest
	logic leading; // This tick is an idle-to-active edge
	logic hostSample; // This tick samples data in
	logic [7:0] hostByte; // Byte complete two cycles after the last edge
	logic hostDone; // Host byte finished this cycle
	logic writeOk; // Buffer write accepted this cycle
	logic hostEnd; // Last clock edge of the byte this cycle
	logic [1:0] sampleDly_r; // Sample strobe, delayed like the data pin
	logic [1:0] doneDly_r; // Byte end, delayed to match
	logic [7:0] hostRx_r; // Host receive shifter, fed late

	assign leading = ~edgeCnt_r[0];
	assign hostSample = (hostState_r == HOST_SHIFT) && halfTick && (leading == clkEdge);
	assign hostByte = sampleDly_r[1] ? {hostRx_r[6:0], sdiSync_r} : hostRx_r;
	assign hostEnd = (hostState_r == HOST_SHIFT) && halfTick && (edgeCnt_r == 4'(EDGE_LAST));
	assign hostDone = doneDly_r[1];

	// Data in reaches logic two flops late and the clock pin one flop
	// late, so each sample and the byte end are taken two cycles after
	// the tick; at the fastest rate the bit would otherwise be stale
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sampleDly_r <= 2'b00;
			doneDly_r <= 2'b00;
			hostRx_r <= BUF_RESET;
		end else begin
			sampleDly_r <= {sampleDly_r[0], hostSample};
			doneDly_r <= {doneDly_r[0], hostEnd};
			if (sampleDly_r[1]) begin
				hostRx_r <= {hostRx_r[6:0], sdiSync_r};
			end
		end
	end

	// Host only starts on a software write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hostState_r <= HOST_IDLE;
			edgeCnt_r <= 4'h0;
			sckLevel_r <= 1'b0;
		end else begin
			case (hostState_r)
				HOST_IDLE: begin
					sckLevel_r <= 1'b0;
					edgeCnt_r <= 4'h0;
					if (writeOk && hostMode) begin
						hostState_r <= HOST_SHIFT;
					end
				end
				HOST_SHIFT: begin
					if (!active || !hostMode) begin
						hostState_r <= HOST_IDLE;
					end else if (halfTick) begin
						sckLevel_r <= ~sckLevel_r;
						edgeCnt_r <= edgeCnt_r + 4'h1;
						if (edgeCnt_r == 4'(EDGE_LAST)) begin
							hostState_r <= HOST_IDLE;
						end
					end
				end
				default: hostState_r <= HOST_IDLE;
			endcase
		end
	end

	// Shifter: loaded by the write, shifted on sampling edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hostSh_r <= BUF_RESET;
			hostSdo_r <= 1'b0;
		end else if (writeOk && hostMode) begin
			hostSh_r <= bufWriteData;
			hostSdo_r <= bufWriteData[BYTE_BITS - 1];
		end else if (hostState_r == HOST_SHIFT && halfTick) begin
			if (hostSample) begin
				hostSh_r <= {hostSh_r[6:0], 1'b0};
			end else begin
				hostSdo_r <= hostSh_r[BYTE_BITS - 1];
			end
		end
	end

	// ------------------------------------------------------------
	// Data buffer and flags
	// ------------------------------------------------------------
	logic busy; // A byte is on the wire
	logic rxDone; // A byte just completed in either mode
	logic [7:0] rxByte; // That byte

	// Client counts as busy while selected; a host write can't race it
	// Host stays busy until its late byte end has landed
	assign busy = (hostState_r == HOST_SHIFT) || (|doneDly_r) || (!hostMode && !ssSync_b_r);
	// Writes are dropped until software acknowledges any collision
	assign writeOk = bufWrite && active && !busy && !write_collision_flag;
	assign rxDone = hostDone || (clientDone && !hostMode);
	assign rxByte = hostDone ? hostByte : clientRx_r;

	// Buffer: written by software, overwritten by a finished byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_data_buffer <= BUF_RESET;
			txByte_r <= BUF_RESET;
		end else if (rxDone) begin
			spi_data_buffer <= rxByte;
		end else if (writeOk) begin
			spi_data_buffer <= bufWriteData;
			txByte_r <= bufWriteData;
		end
	end

	// Collision flag; a new collision beats the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			write_collision_flag <= 1'b0;
		end else if (bufWrite && active && busy) begin
			write_collision_flag <= 1'b1;
		end else if (collisionClear) begin
			write_collision_flag <= 1'b0;
		end
	end

	// Buffer full: set on load, cleared by a read; load wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_buffer_full_flag <= 1'b0;
		end else if (rxDone) begin
			rx_buffer_full_flag <= 1'b1;
		end else if (bufRead) begin
			rx_buffer_full_flag <= 1'b0;
		end
	end

	// Interrupt flag raised with each received byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_irq_flag <= 1'b0;
		end else if (rxDone) begin
			spi_irq_flag <= 1'b1;
		end else if (irqClear) begin
			spi_irq_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Readback images
	// ------------------------------------------------------------
	// Status: two config bits on top, hardware status below
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_status_reg <= STATUS_RESET;
		end else begin
			spi_status_reg <= STATUS_RESET;
			spi_status_reg[STAT_SMP_POS] <= sampleEnd;
			spi_status_reg[STAT_CKE_POS] <= clkEdge;
			spi_status_reg[STAT_BF_POS] <= rx_buffer_full_flag;
		end
	end

	// Control image: bit 7 collision flag, bit 6 zero, other bits read back what was set
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_control_one <= CTRL_RESET;
		end else begin
			spi_control_one <= {5'b00000, rateSel};
			spi_control_one[CTRL_WRITE_COLLISION_FLAG_POS] <= write_collision_flag;
			spi_control_one[CTRL_EN_POS] <= portEnable;
			spi_control_one[CTRL_CKP_POS] <= clkPolarity;
			spi_control_one[CTRL_HOST_POS] <= hostMode;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	logic sdoOeHost_b_r; // Host data drive enable, low drives
	logic sdoOeClient_b_r; // Client data drive enable, low drives

	// Clock pin and enables; clock rests at programmed level
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sckOut <= 1'b0;
			sckOe_b <= 1'b1;
			sdoOeHost_b_r <= 1'b1;
			sdoOeClient_b_r <= 1'b1;
		end else begin
			sckOut <= sckLevel_r ^ clkPolarity;
			sckOe_b <= ~(active & hostMode);
			sdoOeHost_b_r <= ~(active & hostMode);
			// Unselected client lets go of the shared line
			sdoOeClient_b_r <= ~(active & ~hostMode & ~ssSync_b_r);
		end
	end

	// Client first bit must be valid before any clock edge arrives,
	// so the pin picks the loaded MSB until the first edge is seen
	assign sdoOut = hostMode ? hostSdo_r :
		(clientCnt_r == 3'd0) ? txByte_r[BYTE_BITS - 1] : clientSdo_r;
	assign sdoOe_b = hostMode ? sdoOeHost_b_r : sdoOeClient_b_r;

endmodule

`default_nettype wire

/* File: sim/sync_serial_port_spi_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks of the SPI core
// ----------------------------------------
module sync_serial_port_spi_core_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic portEnable,
	input wire logic hostMode,
	input wire logic clkPolarity,
	input wire logic clkEdge,
	input wire logic sampleEnd,
	input wire sync_serial_port_pkg::rate_sel_t rateSel,
	input wire logic bufWrite,
	input wire logic bufRead,
	input wire logic ssIn_b,
	input wire logic [7:0] spi_data_buffer,
	input wire logic [7:0] spi_status_reg,
	input wire logic [7:0] spi_control_one,
	input wire logic write_collision_flag,
	input wire logic rx_buffer_full_flag,
	input wire logic spi_irq_flag,
	input wire logic sckOut,
	input wire logic sckOe_b,
	input wire logic sdoOe_b
);
	import sync_serial_port_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Client left unselected long enough for the select sync
	sequence unsel;
		(!hostMode && ssIn_b) [*6];
	endsequence
	a_unsel_floats: assert property (unsel |-> sdoOe_b)
		else $error("unselected client drives data");
	a_client_no_sck: assert property (!hostMode [*2] |-> sckOe_b)
		else $error("client drives the serial clock");
	a_write_collision_flag_cause: assert property ($rose(write_collision_flag) |-> $past(bufWrite))
		else $error("collision flag without a write");
	a_write_collision_flag_drop: assert property (bufWrite && write_collision_flag |=> $stable(spi_data_buffer))
		else $error("blocked write reached the buffer");
	a_full_cleared: assert property (bufRead |=> !rx_buffer_full_flag)
		else $error("full flag survives a read");
	a_full_irq: assert property ($rose(rx_buffer_full_flag) |-> spi_irq_flag)
		else $error("full flag without irq flag");
	a_sck_rest: assert property ($rose(spi_irq_flag) && hostMode |-> sckOut == clkPolarity)
		else $error("host clock not idle after byte");
	a_div4_half: assert property ($changed(sckOut) && rateSel == RATE_DIV4 |=> $stable(sckOut))
		else $error("host clock half period too short");
	a_status_img: assert property (1'b1 |=>
		spi_status_reg[7:1] == {$past(sampleEnd), $past(clkEdge), 5'h00})
		else $error("status image wrong");
	a_ctrl_img: assert property (1'b1 |=> spi_control_one[5:0] ==
		{$past(portEnable), $past(clkPolarity), $past(hostMode), $past(rateSel)})
		else $error("control image wrong");
endmodule
`default_nettype wire

/* File: sim/spi_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far side: client to a host core, host to a client core
// ----------------------------------------
module spi_far_model (
	input wire logic sck,
	input wire logic pol,
	input wire logic sdoIn,
	output logic sdiOut,
	output logic sckDrive,
	output logic ssOut_b
);
	logic [7:0] sr; // Far shift register
	logic inBit; // Bit caught on the leading edge
	int edges; // Leading edges seen
	wire logic sckN; // Clock with idle level folded to zero
	assign sckN = sck ^ pol;
	assign sdiOut = sr[7]; // MSB always on the line
	initial begin
		sr = 8'h00;
		inBit = 1'b0;
		edges = 0;
		sckDrive = 1'b0;
		ssOut_b = 1'b1;
	end
	// Sample on leading edge, shift on trailing: one bit each way
	always @(posedge sckN) begin
		inBit = sdoIn;
		edges++;
	end
	always @(negedge sckN) begin
		sr = {sr[6:0], inBit};
	end
	// Host role: one select only, set by sel; clock runs even with sel low
	task automatic frame(input int n, input logic sel);
		ssOut_b = ~sel;
		#43;
		repeat (n) begin
			sckDrive = ~pol;
			#6;
			sckDrive = pol;
			#6;
		end
		#43;
		ssOut_b = 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_sync_serial_port_spi_core.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sync_serial_port_spi_core;
	import sync_serial_port_pkg::*;
	// ----------------------------------------
	// Signals and design
	// ----------------------------------------
	typedef struct {rate_sel_t rs; int half; logic [7:0] tx; logic [7:0] far;} row_t;
	logic clk, rst_b, hostMode, sampleEnd, timerTick, selectSyncEn, lastSdo, clkPolarity;
	logic bufWrite, bufRead, collisionClear, irqClear;
	logic [7:0] bufWriteData, spi_data_buffer, spi_status_reg, spi_control_one;
	rate_sel_t rateSel;
	logic write_collision_flag, rx_buffer_full_flag, spi_irq_flag;
	logic sckOut, sckOe_b, sdoOut, sdoOe_b, sdiWire, sckDrive, ssLink_b;
	wire logic sckWire = sckOe_b ? sckDrive : sckOut; // Shared clock pin
	wire logic sdoWire = sdoOe_b ? ~lastSdo : sdoOut; // Released line drifts
	int num_errors, checks_done, cyc;
	row_t rows[5] = '{'{RATE_DIV4, 2, 8'hA5, 8'h3C}, '{RATE_DIV16, 8, 8'h01, 8'h80},
		'{RATE_DIV64, 32, 8'hFF, 8'h00}, '{RATE_TIMER, 4, 8'h5A, 8'hC3},
		'{RATE_RELOAD, 12, 8'h96, 8'h69}};
	always @(sdoOut or sdoOe_b) if (!sdoOe_b) lastSdo = sdoOut;
	sync_serial_port_spi_core dut_u (.clk(clk), .rst_b(rst_b), .protocolSpi(1'b1),
		.portEnable(1'b1), .hostMode(hostMode), .clkPolarity(clkPolarity), .clkEdge(1'b1),
		.sampleEnd(sampleEnd), .rateSel(rateSel), .spi_rate_reload(8'h05),
		.timerTick(timerTick), .selectSyncEn(selectSyncEn), .bufWrite(bufWrite),
		.bufWriteData(bufWriteData), .bufRead(bufRead), .collisionClear(collisionClear),
		.irqClear(irqClear), .spi_data_buffer(spi_data_buffer),
		.spi_status_reg(spi_status_reg), .spi_control_one(spi_control_one),
		.write_collision_flag(write_collision_flag),
		.rx_buffer_full_flag(rx_buffer_full_flag), .spi_irq_flag(spi_irq_flag),
		.sckOut(sckOut), .sckOe_b(sckOe_b), .sckIn(sckWire), .sdoOut(sdoOut),
		.sdoOe_b(sdoOe_b), .sdiIn(sdiWire), .ssIn_b(ssLink_b));
	spi_far_model far_u (.sck(sckWire), .pol(clkPolarity), .sdoIn(sdoWire), .sdiOut(sdiWire),
		.sckDrive(sckDrive), .ssOut_b(ssLink_b));
	// ----------------------------------------
	// Clock, timer tick every 4 cycles, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		timerTick = 1'b0;
		forever begin
			repeat (3) @(negedge clk);
			timerTick = 1'b1;
			@(negedge clk);
			timerTick = 1'b0;
		end
	end
	initial begin
		#500000;
		num_errors++;
		end_sim;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic pulse_write(input logic [7:0] d);
		@(negedge clk);
		bufWrite = 1'b1;
		bufWriteData = d;
		@(negedge clk);
		bufWrite = 1'b0;
	endtask
	// Bounded wait for the byte-done flag
	task automatic wait_irq;
		cyc = 0;
		while (spi_irq_flag !== 1'b1 && cyc < 3000) begin
			@(negedge clk);
			cyc++;
		end
		if (cyc >= 3000) begin
			num_errors++;
			$display("ERROR %0t: byte-done flag never rose", $time);
		end
	endtask
	task automatic clear_rx;
		@(negedge clk);
		bufRead = 1'b1;
		irqClear = 1'b1;
		@(negedge clk);
		bufRead = 1'b0;
		irqClear = 1'b0;
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_b, sampleEnd, selectSyncEn, bufWrite, bufRead, collisionClear, irqClear} = 0;
		{num_errors, checks_done, cyc} = 0;
		hostMode = 1'b1;
		clkPolarity = 1'b0;
		lastSdo = 1'b0;
		bufWriteData = 8'h00;
		rateSel = RATE_DIV4;
		repeat (11) @(negedge clk);
		chk_bit(sdoOe_b, 1'b1);
		chk_byte(spi_data_buffer, BUF_RESET);
		chk_byte(spi_status_reg, STATUS_RESET);
		@(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		chk_bit(sckOe_b, 1'b0);
		$display("test reset done");
		foreach (rows[i]) begin
			rateSel = rows[i].rs;
			far_u.sr = rows[i].far;
			far_u.edges = 0;
			pulse_write(rows[i].tx);
			wait_irq;
			chk_bit(cyc >= 16 * rows[i].half - 4 && cyc <= 16 * rows[i].half + 8, 1'b1);
			chk_byte(spi_data_buffer, rows[i].far);
			chk_byte(far_u.sr, rows[i].tx);
			chk_byte(8'(far_u.edges), 8'h08);
			chk_bit(rx_buffer_full_flag, 1'b1);
			clear_rx;
			chk_bit(rx_buffer_full_flag, 1'b0);
			$display("test row %0d done", i);
		end
		rateSel = RATE_DIV16;
		far_u.sr = 8'hE7;
		pulse_write(8'h3C);
		repeat (10) @(negedge clk);
		pulse_write(8'hFF);
		chk_bit(write_collision_flag, 1'b1);
		wait_irq;
		chk_byte(spi_data_buffer, 8'hE7);
		chk_byte(far_u.sr, 8'h3C);
		clear_rx;
		pulse_write(8'h77);
		repeat (200) @(negedge clk);
		chk_bit(spi_irq_flag, 1'b0);
		collisionClear = 1'b1;
		@(negedge clk);
		collisionClear = 1'b0;
		chk_bit(write_collision_flag, 1'b0);
		$display("test collision done");
		clkPolarity = 1'b1;
		repeat (4) @(negedge clk);
		far_u.sr = 8'h4B;
		far_u.edges = 0;
		pulse_write(8'hD2);
		wait_irq;
		chk_byte(spi_data_buffer, 8'h4B);
		chk_byte(far_u.sr, 8'hD2);
		chk_byte(8'(far_u.edges), 8'h08);
		chk_bit(sckOut, 1'b1);
		clear_rx;
		clkPolarity = 1'b0;
		repeat (4) @(negedge clk);
		$display("test polarity done");
		hostMode = 1'b0;
		sampleEnd = 1'b1;
		repeat (8) @(negedge clk);
		chk_bit(sckOe_b, 1'b1);
		far_u.frame(8, 1'b0);
		repeat (4) @(negedge clk);
		chk_bit(spi_irq_flag, 1'b0);
		chk_bit(sdoOe_b, 1'b1);
		pulse_write(8'hC3);
		far_u.sr = 8'hA5;
		far_u.frame(8, 1'b1);
		repeat (10) @(negedge clk);
		chk_byte(spi_data_buffer, 8'hA5);
		chk_byte(far_u.sr, 8'hC3);
		clear_rx;
		selectSyncEn = 1'b1;
		pulse_write(8'h5A);
		far_u.frame(3, 1'b1);
		repeat (10) @(negedge clk);
		chk_bit(spi_irq_flag, 1'b0);
		far_u.sr = 8'h69;
		far_u.frame(8, 1'b1);
		repeat (10) @(negedge clk);
		chk_byte(spi_data_buffer, 8'h69);
		$display("test client done");
		end_sim;
	end
endmodule
bind sync_serial_port_spi_core sync_serial_port_spi_core_props props_u (.clk, .rst_b,
	.portEnable, .hostMode, .clkPolarity, .clkEdge, .sampleEnd, .rateSel, .bufWrite,
	.bufRead, .ssIn_b, .spi_data_buffer, .spi_status_reg, .spi_control_one,
	.write_collision_flag, .rx_buffer_full_flag, .spi_irq_flag, .sckOut, .sckOe_b,
	.sdoOe_b);
`default_nettype wire
